//--- logic/smc_defs.svh
/*
 Timing counts, register offsets, field positions and reset values for the
 sleep mode controller. Assumes inclusion by the controller module only.
 */
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
// How it works
// - Sleep only when enable bit set
// - Mode field decodes five modes, three reserved
// - Interrupt wake holds core four extra cycles
// - Register file and SRAM kept intact
// - Reset while asleep restarts at reset vector
// - Upper four bits read zero, reset zero
// - Idle stops only core and flash clocks
// - Idle or noise mode starts conversion
// - Noise mode stops io, core, flash clocks
// - Noise mode wake sources limited
// - Power-down stops oscillator and generated clocks
// - Power-down wake sources limited
// - Power-down wake waits fuse start-up time
// - Power-save like power-down plus timer two
// - Power-save timer two wakes only with enables set
// - Power-save oscillators follow timer two clocking
// - Standby keeps oscillator, wakes in six cycles
// - Timer oscillator runs only if asynchronous while asleep
// - External irqs wake deep modes as levels
// - Idle wakes on any interrupt
// ----------------------------------------
// Register map
// ----------------------------------------
`define SMC_ADDR_CTRL      12'h000
`define SMC_ADDR_STATUS    12'h004
`define SMC_ADDR_CONFIG    12'h008
`define SMC_CTRL_RESET     8'h00
`define SMC_CONFIG_RESET   8'h00
`define SMC_SE_BIT         0
`define SMC_SM_LSB         1
`define SMC_SM_MSB         3
`define SMC_CFG_XTAL_BIT   0
`define SMC_CFG_T2EN_BIT   1
`define SMC_CFG_T2ASY_BIT  2
`define SMC_CFG_T2SYN_BIT  3
`define SMC_CFG_ADCEN_BIT  4
`define SMC_CFG_SUT_LSB    5
`define SMC_CFG_SUT_MSB    7
// ----------------------------------------
// Timing counts in cycles
// ----------------------------------------
`define SMC_IRQ_HOLD       4'h4
`define SMC_STANDBY_WAKE   16'h0006
`define SMC_SHORT_WAKE     16'h0001
`endif

//--- logic/smc_pkg.sv
/*
 Types shared by the sleep mode controller. Assumes nothing outside.
 */
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_IDLE    = 3'h0,
      SMC_NOISE   = 3'h1,
      SMC_PDOWN   = 3'h2,
      SMC_PSAVE   = 3'h3,
      SMC_STANDBY = 3'h6
   } smc_mode_t;
   typedef enum logic [3:0] {
      SMC_RUN   = 4'h1,
      SMC_SLEEP = 4'h2,
      SMC_START = 4'h4,
      SMC_HOLD  = 4'h8
   } smc_state_t;
endpackage

//--- logic/smc_ctrl.sv
/*
 Sleep mode controller: control register over APB, sleep state machine,
 clock domain gates and wake filtering. Assumes the core raises a one-cycle
 sleep_exec when it executes its sleep instruction and stalls while core_halt.
 */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "smc_defs.svh"
module smc_ctrl
   import smc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Core side
   input  wire logic        sleep_exec,
   input  wire logic        global_irq_en,
   input  wire logic        sys_reset_req,
   output logic             core_halt,
   output logic             irq_resume,
   output logic             reset_vector,
   // Wake sources
   input  wire logic        ext_irq_level,
   input  wire logic        ext_irq_edge,
   input  wire logic        pin_change_irq,
   input  wire logic        twi_addr_match,
   input  wire logic        watchdog_irq,
   input  wire logic        timer2_irq,
   input  wire logic [1:0]  timer2_irq_mask,
   input  wire logic        spm_ready_irq,
   input  wire logic        adc_done_irq,
   input  wire logic        other_io_irq,
   // Clock gates and conversion start
   output logic             clk_cpu_en,
   output logic             clk_flash_en,
   output logic             clk_io_en,
   output logic             clk_adc_en,
   output logic             async_clock_domain_en,
   output logic             main_osc_en,
   output logic             timer_osc_en,
   output logic             adc_start
);
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [7:0]  ctrl_q, ctrl_d, cfg_q, cfg_d;
   logic [31:0] rdata_d;
   logic        ready_d, err_d;
   logic        acc, hit;
   smc_state_t  st_q, st_d;
   smc_mode_t   mode_q, mode_d;
   logic [15:0] cnt_q, cnt_d;
   logic        wake_irq_q, wake_irq_d;
   logic        irq_res_q, irq_res_d, rv_q, rv_d, adc_q, adc_d;
   logic [6:0]  gate_q, gate_d;
   logic        halt_d;
   logic        legal, wake, sleep_go;
   logic [15:0] startup;

   assign acc = psel && penable;
   assign hit = (paddr == `SMC_ADDR_CTRL) || (paddr == `SMC_ADDR_STATUS) || (paddr == `SMC_ADDR_CONFIG);

   always_comb begin
      ctrl_d  = ctrl_q;
      cfg_d   = cfg_q;
      rdata_d = 32'h0;
      ready_d = 1'b0;
      err_d   = 1'b0;
      if (psel && !penable) begin
         ready_d = 1'b1;
      end
      if (acc && pready) begin
         if (pwrite && paddr == `SMC_ADDR_CTRL) begin
            ctrl_d = {4'h0, pwdata[3:0]};
         end
         if (pwrite && paddr == `SMC_ADDR_CONFIG) begin
            cfg_d = pwdata[7:0];
         end
      end
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `SMC_ADDR_CTRL:   rdata_d = {24'h0, ctrl_q};
            `SMC_ADDR_STATUS: rdata_d = {24'h0, st_q, 1'b0, mode_q};
            `SMC_ADDR_CONFIG: rdata_d = {24'h0, cfg_q};
            default:          rdata_d = 32'h0;
         endcase
      end
      if (psel && !penable && !hit) begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `SMC_CTRL_RESET;
         cfg_q   <= `SMC_CONFIG_RESET;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         cfg_q   <= cfg_d;
         prdata  <= rdata_d;
         pready  <= ready_d;
         pslverr <= err_d;
      end
   end

   // ----------------------------------------
   // Mode decode and wake filtering
   // ----------------------------------------
   // Standby without a crystal falls back to no gating at all
   always_comb begin
      legal = 1'b0;
      unique case (ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB])
         SMC_IDLE, SMC_NOISE, SMC_PDOWN, SMC_PSAVE: legal = 1'b1;
         SMC_STANDBY: legal = cfg_q[`SMC_CFG_XTAL_BIT];
         default:     legal = 1'b0;
      endcase
   end

   assign sleep_go = (st_q == SMC_RUN) && sleep_exec && ctrl_q[`SMC_SE_BIT] && legal;

   // Deep modes see external irqs as levels only
   always_comb begin
      wake       = 1'b0;
      wake_irq_d = wake_irq_q;
      unique case (mode_q)
         SMC_IDLE:  wake = ext_irq_level || ext_irq_edge || pin_change_irq || twi_addr_match
                           || watchdog_irq || timer2_irq || spm_ready_irq || adc_done_irq
                           || other_io_irq;
         SMC_NOISE: wake = adc_done_irq || watchdog_irq || twi_addr_match || timer2_irq
                           || spm_ready_irq || ext_irq_level || pin_change_irq;
         SMC_PSAVE: wake = ext_irq_level || pin_change_irq || twi_addr_match || watchdog_irq
                           || (timer2_irq && (|timer2_irq_mask) && global_irq_en
                               && cfg_q[`SMC_CFG_T2EN_BIT]);
         default:   wake = ext_irq_level || pin_change_irq || twi_addr_match
                           || watchdog_irq;
      endcase
      if (st_q == SMC_SLEEP) begin
         wake_irq_d = !sys_reset_req;
      end
   end

   // Fuse start-up code n gives 2^n cycles, clock restart time
   assign startup = (mode_q == SMC_STANDBY) ? `SMC_STANDBY_WAKE :
                    (mode_q == SMC_PDOWN || mode_q == SMC_PSAVE)
                    ? (16'h0001 << cfg_q[`SMC_CFG_SUT_MSB:`SMC_CFG_SUT_LSB]) : `SMC_SHORT_WAKE;

   // ----------------------------------------
   // Sleep state machine
   // ----------------------------------------
   // Core state is never touched: only clocks stop, so registers and SRAM keep data
   always_comb begin
      st_d      = st_q;
      mode_d    = mode_q;
      cnt_d     = cnt_q;
      irq_res_d = 1'b0;
      rv_d      = 1'b0;
      adc_d     = 1'b0;
      unique case (st_q)
         SMC_RUN: begin
            if (sleep_go) begin
               st_d   = SMC_SLEEP;
               mode_d = smc_mode_t'(ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB]);
               adc_d  = cfg_q[`SMC_CFG_ADCEN_BIT]
                        && (ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB] == SMC_IDLE
                            || ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB] == SMC_NOISE);
            end
         end
         SMC_SLEEP: begin
            if (sys_reset_req || wake) begin
               st_d  = SMC_START;
               cnt_d = startup;
            end
         end
         SMC_START: begin
            if (cnt_q <= 16'h0001) begin
               st_d  = wake_irq_q ? SMC_HOLD : SMC_RUN;
               cnt_d = {12'h0, `SMC_IRQ_HOLD};
               rv_d  = !wake_irq_q;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         SMC_HOLD: begin
            if (cnt_q <= 16'h0001) begin
               st_d      = SMC_RUN;
               irq_res_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
      endcase
   end

   // Gate vector: cpu, flash, io, adc, async, main osc, timer osc
   always_comb begin
      gate_d = 7'h7f;
      if (st_d == SMC_SLEEP || st_d == SMC_START) begin
         unique case (mode_d)
            SMC_IDLE:    gate_d = {2'b00, 3'b111, 1'b1, cfg_q[`SMC_CFG_T2ASY_BIT]};
            SMC_NOISE:   gate_d = {3'b000, 2'b11, 1'b1, cfg_q[`SMC_CFG_T2ASY_BIT]};
            SMC_PDOWN:   gate_d = 7'h00;
            SMC_PSAVE:   gate_d = {4'h0, 1'b1, cfg_q[`SMC_CFG_T2SYN_BIT],
                                   cfg_q[`SMC_CFG_T2ASY_BIT]};
            SMC_STANDBY: gate_d = 7'h02;
         endcase
      end
      halt_d = (st_d != SMC_RUN);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= SMC_RUN;
         mode_q     <= SMC_IDLE;
         cnt_q      <= 16'h0000;
         wake_irq_q <= 1'b0;
         irq_res_q  <= 1'b0;
         rv_q       <= 1'b0;
         adc_q      <= 1'b0;
         gate_q     <= 7'h7f;
         core_halt  <= 1'b0;
      end else begin
         st_q       <= st_d;
         mode_q     <= mode_d;
         cnt_q      <= cnt_d;
         wake_irq_q <= wake_irq_d;
         irq_res_q  <= irq_res_d;
         rv_q       <= rv_d;
         adc_q      <= adc_d;
         gate_q     <= gate_d;
         core_halt  <= halt_d;
      end
   end

   assign irq_resume            = irq_res_q;
   assign reset_vector          = rv_q;
   assign adc_start             = adc_q;
   assign clk_cpu_en            = gate_q[6];
   assign clk_flash_en          = gate_q[5];
   assign clk_io_en             = gate_q[4];
   assign clk_adc_en            = gate_q[3];
   assign async_clock_domain_en = gate_q[2];
   assign main_osc_en           = gate_q[1];
   assign timer_osc_en          = gate_q[0];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_noop_no_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_RUN && sleep_exec && !ctrl_q[0]) |=> (st_q == SMC_RUN && clk_cpu_en))
      else $error("sleep taken while disabled");
   a_enter_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_go |=> (st_q == SMC_SLEEP && core_halt && !clk_cpu_en))
      else $error("sleep not entered");
   a_reserved_run: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_RUN && !legal) |=> clk_cpu_en && clk_io_en)
      else $error("clock gated on reserved code");
   a_idle_gates: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && mode_q == SMC_IDLE) |-> (!clk_cpu_en && !clk_flash_en && clk_io_en))
      else $error("idle gating wrong");
   a_noise_gates: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && mode_q == SMC_NOISE) |-> (!clk_io_en && clk_adc_en))
      else $error("noise gating wrong");
   a_pdown_off: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && mode_q == SMC_PDOWN) |-> (!main_osc_en && !async_clock_domain_en))
      else $error("power-down clocks running");
   a_ctrl_upper: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[7:4] == 4'h0)
      else $error("upper control bits set");
   a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_START && st_d == SMC_HOLD) |=> core_halt [*4] ##1 irq_resume)
      else $error("hold not four cycles");
   a_standby_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && mode_q == SMC_STANDBY && wake) |-> ##7 (st_q != SMC_START))
      else $error("standby wake slow");
   a_reset_vec: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && sys_reset_req) |-> ##[1:300] reset_vector)
      else $error("reset wake lost");
   a_edge_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == SMC_SLEEP && mode_q == SMC_PDOWN && !sys_reset_req && !ext_irq_level
       && !pin_change_irq && !twi_addr_match && !watchdog_irq) |=> st_q == SMC_SLEEP)
      else $error("illegal wake source");
   c_idle_wake: cover property (@(posedge pclk) st_q == SMC_SLEEP && mode_q == SMC_IDLE && wake);
   c_psave_t2:  cover property (@(posedge pclk) st_q == SMC_SLEEP && mode_q == SMC_PSAVE && timer2_irq && wake);
   c_reset_wk:  cover property (@(posedge pclk) reset_vector);
endmodule // smc_ctrl
`default_nettype wire

//--- verif/smc_core_model.sv
/*
 Partner model of the processor core and of the level-triggered external
 interrupt source. Assumes the bench asks for sleep and level events.
 */
`timescale 1ns/10ps
`default_nettype none
module smc_core_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Bench requests
   input  wire logic sleep_go,
   input  wire logic level_go,
   // Controller answers
   input  wire logic irq_resume,
   input  wire logic reset_vector,
   // Toward the controller
   output logic      sleep_exec,
   output logic      ext_irq_level
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_exec    <= 1'b0;
         ext_irq_level <= 1'b0;
      end else begin
         // Sleep instruction retires one cycle after the bench asks for it
         sleep_exec <= sleep_go;
         // Level is held until the controller has acted on it; the answer wins so
         // a request still standing on the resume edge cannot leave it stuck high
         if (irq_resume || reset_vector)
            ext_irq_level <= 1'b0;
         else if (level_go)
            ext_irq_level <= 1'b1;
      end
   end
endmodule // smc_core_model
`default_nettype wire

//--- verif/smc_ctrl_tb_top.sv
/*
 Self-checking bench for the sleep mode controller. Assumes the core
 model stands on the core side and the bench drives APB and wake inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_tb_top;
   import smc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, sleep_exec, gie, rst_req, core_halt;
   logic        irq_resume, reset_vector, ext_lvl, sleep_go, level_go, adc_start;
   logic [1:0]  t2_mask;
   logic [7:0]  wk;
   wire  [6:0]  gates;
   int          bad_count, num_checks, cyc;

   smc_core_model smc_core_model_i (.pclk(pclk), .presetn(presetn), .sleep_go(sleep_go),
      .level_go(level_go), .irq_resume(irq_resume), .reset_vector(reset_vector),
      .sleep_exec(sleep_exec), .ext_irq_level(ext_lvl));
   smc_ctrl smc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_exec(sleep_exec), .global_irq_en(gie),
      .sys_reset_req(rst_req), .core_halt(core_halt), .irq_resume(irq_resume),
      .reset_vector(reset_vector), .ext_irq_level(ext_lvl), .ext_irq_edge(wk[0]),
      .pin_change_irq(wk[1]), .twi_addr_match(wk[2]), .watchdog_irq(wk[3]),
      .timer2_irq(wk[4]), .timer2_irq_mask(t2_mask), .spm_ready_irq(wk[5]),
      .adc_done_irq(wk[6]), .other_io_irq(wk[7]), .clk_cpu_en(gates[6]),
      .clk_flash_en(gates[5]), .clk_io_en(gates[4]), .clk_adc_en(gates[3]),
      .async_clock_domain_en(gates[2]), .main_osc_en(gates[1]),
      .timer_osc_en(gates[0]), .adc_start(adc_start));

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Expected word is {core_halt, gates}; msk hides the timer oscillator when awake
   task automatic enter(input logic [7:0] cfg, input logic [3:0] ctl, input logic [7:0] exp,
                        input logic [7:0] msk);
      logic seen;
      apb(1'b1, 12'h008, {24'h0, cfg});
      apb(1'b1, 12'h000, {28'h0, ctl});
      @(posedge pclk);
      sleep_go <= 1'b1;
      @(posedge pclk);
      sleep_go <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         @(posedge pclk);
         seen = seen | adc_start;
      end
      chk("halt_gates", {24'h0, exp & msk}, {24'h0, {core_halt, gates} & msk});
      chk("adc_start", {31'h0, ctl[0] & cfg[4] & (ctl[3:2] == 2'b00)}, {31'h0, seen});
   endtask

   // Source b (8 is the held level); lo is start-up plus the four halt cycles
   task automatic wake(input int b, input int lo, input logic yes);
      int n;
      if (b == 8)
         level_go <= 1'b1;
      else
         wk[b] <= 1'b1;
      n = 0;
      while (irq_resume !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      wk       <= 8'h00;
      level_go <= 1'b0;
      chk("woken", {31'h0, yes}, {31'h0, irq_resume});
      chk("halt_span", 32'h1, {31'h0, n >= lo && (n <= lo + 4 || !yes)});
      chk("halted", {31'h0, !yes}, {31'h0, core_halt});
      if (yes)
         apb(1'b1, 12'h000, 32'h0);
   endtask

   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl_rst", 32'h0, rd);
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl_ro", 32'h0000000f, rd);
      apb(1'b1, 12'h00c, 32'h5);
      chk("unmapped_err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped_rd", 32'h1, {31'h0, err});
      chk("unmapped_val", 32'h0, rd);
      apb(1'b1, 12'h000, 32'h0);
   endtask

   task automatic t_noop();
      enter(8'h00, 4'b0100, 8'h7f, 8'hfe);
      for (int c = 4; c < 8; c++) begin
         if (c != 6)
            enter(8'h00, {c[2:0], 1'b1}, 8'h7f, 8'hfe);
      end
      enter(8'h00, 4'b1101, 8'h7f, 8'hfe);
   endtask

   task automatic t_idle();
      enter(8'h14, 4'b0001, 8'b1_0011111, 8'hff);
      wake(7, 5, 1'b1);
   endtask

   task automatic t_noise();
      enter(8'h10, 4'b0011, 8'b1_0001110, 8'hff);
      wake(7, 0, 1'b0);
      wake(6, 5, 1'b1);
   endtask

   task automatic t_pdown();
      enter(8'h40, 4'b0101, 8'b1_0000000, 8'hff);
      wake(0, 0, 1'b0);
      wake(4, 0, 1'b0);
      wake(8, 8, 1'b1);
   endtask

   task automatic t_psave();
      gie     <= 1'b0;
      t2_mask <= 2'b11;
      enter(8'h06, 4'b0111, 8'b1_0000101, 8'hff);
      wake(4, 0, 1'b0);
      gie <= 1'b1;
      wake(4, 5, 1'b1);
   endtask

   task automatic t_standby();
      enter(8'h01, 4'b1101, 8'b1_0000010, 8'hff);
      wake(2, 10, 1'b1);
   endtask

   task automatic t_reset();
      int n;
      enter(8'h00, 4'b0001, 8'b1_0011110, 8'hff);
      rst_req <= 1'b1;
      n = 0;
      while (reset_vector !== 1'b1 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      chk("restart", 32'h1, {31'h0, reset_vector});
      chk("no_resume", 32'h0, {31'h0, irq_resume});
      rst_req <= 1'b0;
      @(posedge pclk);
      chk("running", 32'h0, {31'h0, core_halt});
   endtask

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Cut a hang short well beyond the few hundred cycles the run needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, sleep_go, level_go, gie, rst_req} = 8'h00;
      {paddr, pwdata, wk, t2_mask} = '0;
      {bad_count, num_checks, cyc} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_noop();
      t_idle();
      t_noise();
      t_pdown();
      t_psave();
      t_standby();
      t_reset();
      close_out();
   end
endmodule // smc_ctrl_tb_top
`default_nettype wire
